// ==== hw/mrd_fifo.sv ====
// Parameterised valid/ready FIFO for queued read commands
`timescale 1ns/1ns
module mrd_fifo
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic                        full;
    logic                        nonempty;
  } mrd_fifo_state_t;

  mrd_fifo_state_t st;
  mrd_fifo_state_t next_st;
  logic            push;
  logic            pop;

  always_comb
  begin
    next_st = st;
    push    = in_valid && !st.full;
    pop     = out_ready && st.nonempty;
    if (push)
    begin
      next_st.mem[st.wptr] = in_data;
      next_st.wptr = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
    end
    if (pop)
      next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
    if (push && !pop)
      next_st.count = st.count + 1'b1;
    else if (pop && !push)
      next_st.count = st.count - 1'b1;
    // Flags registered so ready and valid carry no logic
    next_st.full     = (next_st.count == (AW + 1)'(DEPTH));
    next_st.nonempty = (next_st.count != '0);
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign in_ready  = !st.full;
  assign out_valid = st.nonempty;
  assign out_data  = st.mem[st.rptr];

  a_full_refuses : assert property (@(posedge clock) disable iff (!resetn)
    st.full |=> (st.count == $past(st.count)) || $past(out_ready))
    else $error("FIFO grew while full");

endmodule

// ==== hw/mrd_mode_decode.sv ====
// Mode register 0/1 capture, burst ordering and latency timing
`timescale 1ns/1ns
module mrd_mode_decode
(
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         resetn,
  // Command and address pins
  input  wire logic                         cs_n,
  input  wire logic                         ras_n,
  input  wire logic                         cas_n,
  input  wire logic                         we_n,
  input  wire logic [2:0]                   ba,
  input  wire logic [mrd_pkg::ADDR_W-1:0]   addr,
  // Power state and termination inputs
  input  wire logic                         sr_enter,
  input  wire logic                         sr_exit,
  input  wire logic                         odt,
  input  wire logic [1:0]                   rtt_wr_code,
  // Register contents and decoded settings
  output logic      [mrd_pkg::ADDR_W-1:0]   burst_latency_config,
  output logic      [mrd_pkg::ADDR_W-1:0]   dll_drive_term_config,
  output logic      [4:0]                   cas_latency,
  output logic      [5:0]                   read_latency,
  output logic      [2:0]                   write_recovery,
  output logic                              pd_fast_exit,
  output logic      [1:0]                   drive_code,
  output logic                              dll_enabled,
  output logic                              dll_reset_pulse,
  output mrd_pkg::mrd_term_t                term_sel,
  // Read beat stream
  output logic                              rd_cmd_ready,
  output logic                              rd_beat_valid,
  output logic      [2:0]                   rd_beat_col,
  output logic                              rd_dq_oe,
  // Write beat stream
  output logic                              wr_start,
  output logic                              wr_beat_valid,
  output logic      [2:0]                   wr_beat_col
);
  import mrd_pkg::*;

  localparam int N = WR_START_BL8;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0]  cfg0;
    logic [ADDR_W-1:0]  cfg1;
    logic               self_ref;
    logic [STAMP_W-1:0] now;
    logic [4:0]         cas_latency;
    logic [5:0]         read_latency;
    logic               dll_enabled;
    logic               dll_reset_pulse;
    mrd_term_t          term_sel;
    mrd_rd_state_t      rd_state;
    logic [2:0]         rd_ctr;
    logic [2:0]         rd_ca;
    logic               rd_chop;
    logic [STAMP_W-1:0] rd_stamp;
    logic               rd_beat_valid;
    logic [2:0]         rd_beat_col;
    logic               rd_dq_oe;
    logic [N-1:0]       wp_valid;
    logic [N-1:0]       wp_half;
    logic [N-1:0]       wp_chop;
    logic [N-1:0]       wp_fixed;
    logic               wr_active;
    logic [2:0]         wr_ctr;
    logic               wr_half;
    logic               wr_chop;
    logic               wr_start;
    logic               wr_beat_valid;
    logic [2:0]         wr_beat_col;
  } mrd_state_t;

  mrd_state_t        st;
  mrd_state_t        next_st;
  logic              is_mrs;
  logic              is_rd;
  logic              is_wr;
  logic              cmd_chop;
  logic [1:0]        bl_mode;
  logic              head_valid;
  logic [DESC_W-1:0] head;
  logic              pop;
  logic [STAMP_W-1:0] age;
  logic              fifo_ready;
  logic              tap_fix;
  logic              tap_full;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] cl_of(input logic [ADDR_W-1:0] c);
    cl_of = CL_BASE + {2'h0, c[CL_HI_LSB +: 3]} + (c[CL_LO_BIT] ? CL_EXT : 5'h00);
  endfunction

  function automatic logic [5:0] rl_of(input logic [ADDR_W-1:0] c0,
                                       input logic [ADDR_W-1:0] c1);
    logic [5:0] cl;
    logic [5:0] al;
    cl = {1'b0, cl_of(c0)};
    unique case (c1[AL_LSB +: 2])
      AL_CL_M1: al = cl - 6'h01;
      AL_CL_M2: al = cl - 6'h02;
      default:  al = 6'h00;
    endcase
    rl_of = al + cl;
  endfunction

  // Sequential wraps the low two bits; interleave XORs all three
  function automatic logic [2:0] order_of(input logic [2:0] ca,
                                          input logic [2:0] ctr,
                                          input logic       intl);
    order_of = intl ? (ca ^ ctr) : {ca[2] ^ ctr[2], ca[1:0] + ctr[1:0]};
  endfunction

  // ****************************************
  // Command decode
  // ****************************************
  assign is_mrs  = !cs_n && !ras_n && !cas_n && !we_n;
  assign is_rd   = !cs_n && ras_n && !cas_n && we_n;
  assign is_wr   = !cs_n && ras_n && !cas_n && !we_n;
  assign bl_mode = st.cfg0[BL_LSB +: 2];
  // Reserved burst code falls back to BL8
  assign cmd_chop = (bl_mode == BL_FIX4) || ((bl_mode == BL_OTF) && !addr[BC_BIT]);

  // ****************************************
  // Read command queue
  // ****************************************
  mrd_fifo #(
    .WIDTH (DESC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_queue (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (is_rd),
    .in_data   ({st.now, addr[2:0], cmd_chop}),
    .in_ready  (fifo_ready),
    .out_valid (head_valid),
    .out_data  (head),
    .out_ready (pop)
  );

  assign age = st.now - head[DESC_W-1 -: STAMP_W];
  // Burst starts one cycle early since beat outputs are registered
  assign pop = (st.rd_state == RD_IDLE) && head_valid &&
               (age >= (STAMP_W'(st.read_latency) - STAMP_W'(1)));

  // Write taps: fixed chop taps two stages before the full-length tap
  assign tap_full = st.wp_valid[N-1] && !st.wp_fixed[N-1];
  assign tap_fix  = st.wp_valid[N-1-WR_CHOP_PULL] && st.wp_fixed[N-1-WR_CHOP_PULL];

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st                 = st;
    next_st.now             = st.now + 1'b1;
    next_st.dll_reset_pulse = 1'b0;
    next_st.wr_start        = 1'b0;
    next_st.wr_beat_valid   = 1'b0;
    // Bit stays set one cycle, then the DLL reset has been issued
    if (st.cfg0[DLLRST_BIT])
    begin
      next_st.cfg0[DLLRST_BIT] = 1'b0;
      next_st.dll_reset_pulse  = 1'b1;
    end
    if (is_mrs && (ba == BA_CFG0))
      next_st.cfg0 = addr;
    if (is_mrs && (ba == BA_CFG1))
      next_st.cfg1 = addr;
    if (sr_enter)
      next_st.self_ref = 1'b1;
    else if (sr_exit)
      next_st.self_ref = 1'b0;
    next_st.dll_enabled  = !next_st.cfg1[DLL_OFF_BIT] && !next_st.self_ref;
    next_st.cas_latency  = cl_of(next_st.cfg0);
    next_st.read_latency = rl_of(next_st.cfg0, next_st.cfg1);

    // Write pipeline; low column bits never enter it
    next_st.wp_valid = {st.wp_valid[N-2:0], is_wr};
    next_st.wp_half  = {st.wp_half[N-2:0], addr[2]};
    next_st.wp_chop  = {st.wp_chop[N-2:0], cmd_chop};
    next_st.wp_fixed = {st.wp_fixed[N-2:0], bl_mode == BL_FIX4};

    // Write beat engine
    if (st.wr_active)
    begin
      next_st.wr_ctr = st.wr_ctr + 3'h1;
      if ((st.wr_chop && (st.wr_ctr == 3'h3)) || (st.wr_ctr == 3'h7))
        next_st.wr_active = 1'b0;
    end
    if (tap_fix || tap_full)
    begin
      next_st.wr_start  = 1'b1;
      next_st.wr_active = 1'b1;
      next_st.wr_ctr    = 3'h0;
      next_st.wr_half   = tap_fix ? st.wp_half[N-1-WR_CHOP_PULL] : st.wp_half[N-1];
      next_st.wr_chop   = tap_fix ? 1'b1 : st.wp_chop[N-1];
    end
    if (next_st.wr_active)
    begin
      next_st.wr_beat_valid = 1'b1;
      next_st.wr_beat_col   = next_st.wr_chop ? {next_st.wr_half, next_st.wr_ctr[1:0]}
                                              : next_st.wr_ctr;
    end

    // Read beat engine
    unique case (st.rd_state)
      RD_IDLE:
      begin
        if (pop)
        begin
          next_st.rd_state = RD_BURST;
          next_st.rd_ctr   = 3'h0;
          next_st.rd_ca    = head[3:1];
          next_st.rd_chop  = head[0];
          next_st.rd_stamp = head[DESC_W-1 -: STAMP_W];
        end
      end
      RD_BURST:
      begin
        next_st.rd_ctr = st.rd_ctr + 3'h1;
        if (st.rd_ctr == 3'h7)
          next_st.rd_state = RD_IDLE;
      end
    endcase
    // Chop bursts leave the last four slots undriven
    next_st.rd_dq_oe = (next_st.rd_state == RD_BURST) &&
                       !(next_st.rd_chop && next_st.rd_ctr[2]);
    next_st.rd_beat_valid = next_st.rd_dq_oe;
    next_st.rd_beat_col   = order_of(next_st.rd_ca, next_st.rd_ctr,
                                     st.cfg0[BT_BIT]);

    // Termination; no nominal ODT while the DLL is off, write termination still follows ODT
    if (odt && next_st.wr_active && (rtt_wr_code != 2'h0))
      next_st.term_sel = TERM_WR;
    else if (odt && next_st.dll_enabled &&
             ({st.cfg1[RTT2_BIT], st.cfg1[RTT1_BIT], st.cfg1[RTT0_BIT]} != 3'h0))
      next_st.term_sel = TERM_NOM;
    else
      next_st.term_sel = TERM_OFF;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      st          <= '0;
      st.cfg0     <= CFG0_RST;
      st.cfg1     <= CFG1_RST;
      st.rd_state <= RD_IDLE;
      st.term_sel <= TERM_OFF;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign burst_latency_config  = st.cfg0;
  assign dll_drive_term_config = st.cfg1;
  assign cas_latency           = st.cas_latency;
  assign read_latency          = st.read_latency;
  assign write_recovery        = st.cfg0[WR_LSB +: 3];
  assign pd_fast_exit          = st.cfg0[PPD_BIT];
  assign drive_code            = {st.cfg1[DRV_HI_BIT], st.cfg1[DRV_LO_BIT]};
  assign dll_enabled           = st.dll_enabled;
  assign dll_reset_pulse       = st.dll_reset_pulse;
  assign term_sel              = st.term_sel;
  assign rd_cmd_ready          = fifo_ready;
  assign rd_beat_valid         = st.rd_beat_valid;
  assign rd_beat_col           = st.rd_beat_col;
  assign rd_dq_oe              = st.rd_dq_oe;
  assign wr_start              = st.wr_start;
  assign wr_beat_valid         = st.wr_beat_valid;
  assign wr_beat_col           = st.wr_beat_col;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  localparam int WR_DLY8 = WR_START_BL8 + 1;
  localparam int WR_DLY4 = WR_START_BL8 - 1;
  sequence s_dll_set;
    is_mrs && (ba == BA_CFG0) && addr[DLLRST_BIT];
  endsequence
  sequence s_dll_done;
    st.cfg0[DLLRST_BIT] ##1 (dll_reset_pulse && !st.cfg0[DLLRST_BIT]);
  endsequence

  a_cfg0_load : assert property (
    (is_mrs && (ba == BA_CFG0)) |=> (st.cfg0[12:9] == $past(addr[12:9])) &&
                                    (st.cfg0[7:0] == $past(addr[7:0])))
    else $error("register zero not loaded");
  a_cfg1_load : assert property (
    (is_mrs && (ba == BA_CFG1)) |=> (st.cfg1 == $past(addr)) &&
                                    (drive_code == {$past(addr[5]), $past(addr[1])}))
    else $error("register one not loaded");
  a_dll_selfclear : assert property (
    s_dll_set ##1 !(is_mrs && (ba == BA_CFG0) && addr[DLLRST_BIT]) |-> s_dll_done)
    else $error("DLL reset bit did not clear");
  a_wr_fixed_early : assert property (
    (is_wr && (bl_mode == BL_FIX4)) |-> ##WR_DLY4 wr_start)
    else $error("fixed chop write not pulled in");
  a_wr_otf_late : assert property (
    (is_wr && (bl_mode == BL_OTF) && !addr[BC_BIT]) |-> ##WR_DLY8 wr_start)
    else $error("on-the-fly chop write moved");
  a_chop_hiz : assert property (
    (pop && head[0]) |=> rd_dq_oe [*4] ##1 !rd_dq_oe [*4])
    else $error("chop read slots wrong");
  a_seq_halves : assert property (
    (pop && !head[0] && !st.cfg0[BT_BIT]) |=> ##4
      (rd_beat_col == {!$past(rd_beat_col[2], 4), $past(rd_beat_col[1:0], 4)}))
    else $error("sequential half order wrong");
  a_intl_order : assert property (
    (pop && !head[0] && st.cfg0[BT_BIT]) |=> ##1 (rd_beat_col == ($past(rd_beat_col) ^ 3'h1)))
    else $error("interleaved order wrong");
  a_rd_latency : assert property (
    $rose(rd_beat_valid) |-> ((st.now - st.rd_stamp) >= STAMP_W'(read_latency)))
    else $error("read data too early");
  a_dll_selfref : assert property (
    (sr_enter && !sr_exit) |=> !dll_enabled ##1 (dll_enabled || st.self_ref))
    else $error("DLL not off in self-refresh");
  a_term_wr : assert property (
    (odt && (tap_fix || tap_full) && (rtt_wr_code != 2'h0)) |=> (term_sel == TERM_WR))
    else $error("write termination not applied");
endmodule

// ==== pkg/mrd_pkg.sv ====
// Constants and types for the mode register 0/1 decode block
// Function
// - CAS latency from A2 and A4-A6, whole cycles
// - Read data after additive plus CAS latency
// - A3 picks sequential or interleaved burst order
// - A0-A1 pick BC4, BL8 or on-the-fly
// - Sequential BL8 wraps within half, then other half
// - Interleaved BL8 order is start XOR counter
// - Chop read: four beats, then four idle slots
// - Writes ignore low column bits, fixed order
// - Fixed chop write starts two clocks earlier
// - On-the-fly chop write starts like BL8
// - DLL reset bit clears itself after use
// - A9-A11 hold write recovery, at least minimum
// - A12 picks slow or fast power-down exit
// - MRS with only BA0 high loads register one
// - DLL off in self-refresh, back on exit
// - Drive impedance from A1 and A5
// - Write termination applies even with nominal off
// - MRS with all bank bits low loads register zero
package mrd_pkg;

  // ****************************************
  // Widths and command decode
  // ****************************************
  localparam int         ADDR_W     = 13;
  // Wide enough that a full queue of bursts never wraps the age
  localparam int         STAMP_W    = 9;
  localparam logic [2:0] BA_CFG0    = 3'h0;
  localparam logic [2:0] BA_CFG1    = 3'h1;

  // ****************************************
  // burst_latency_config fields
  // ****************************************
  localparam int         BL_LSB     = 0;
  localparam int         CL_LO_BIT  = 2;
  localparam int         BT_BIT     = 3;
  localparam int         CL_HI_LSB  = 4;
  localparam int         TM_BIT     = 7;
  localparam int         DLLRST_BIT = 8;
  localparam int         WR_LSB     = 9;
  localparam int         PPD_BIT    = 12;
  localparam logic [1:0] BL_FIX8    = 2'h0;
  localparam logic [1:0] BL_OTF     = 2'h1;
  localparam logic [1:0] BL_FIX4    = 2'h2;
  localparam logic [4:0] CL_BASE    = 5'h04;
  localparam logic [4:0] CL_EXT     = 5'h08;

  // ****************************************
  // dll_drive_term_config fields
  // ****************************************
  localparam int         DLL_OFF_BIT = 0;
  localparam int         DRV_LO_BIT  = 1;
  localparam int         RTT0_BIT    = 2;
  localparam int         AL_LSB      = 3;
  localparam int         DRV_HI_BIT  = 5;
  localparam int         RTT1_BIT    = 6;
  localparam int         WLVL_BIT    = 7;
  localparam int         RTT2_BIT    = 9;
  localparam int         QOFF_BIT    = 12;
  localparam int         BC_BIT      = 12;
  localparam logic [1:0] AL_ZERO     = 2'h0;
  localparam logic [1:0] AL_CL_M1    = 2'h1;
  localparam logic [1:0] AL_CL_M2    = 2'h2;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [12:0] CFG0_RST     = 13'h0000;
  localparam logic [12:0] CFG1_RST     = 13'h0000;
  localparam int          WR_START_BL8 = 6;
  localparam int          WR_CHOP_PULL = 2;
  localparam int          FIFO_DEPTH   = 32;
  localparam int          DESC_W       = STAMP_W + 4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RD_IDLE  = 2'b01,
    RD_BURST = 2'b10
  } mrd_rd_state_t;

  typedef enum logic [1:0] {
    TERM_OFF = 2'h0,
    TERM_NOM = 2'h1,
    TERM_WR  = 2'h2
  } mrd_term_t;

endpackage

// ==== tb/mrd_ctrl_model.sv ====
// Memory controller model issuing mode register, read and write commands
`timescale 1ns/1ns
module mrd_ctrl_model
#(
  parameter int DLL_LOCK = 16
)
(
  // Clock and queue status
  input  wire logic                       clock,
  input  wire logic                       rd_cmd_ready,
  // Command and address pins
  output logic                            cs_n,
  output logic                            ras_n,
  output logic                            cas_n,
  output logic                            we_n,
  output logic [2:0]                      ba,
  output logic [mrd_pkg::ADDR_W-1:0]      addr
);
  import mrd_pkg::*;
  int cyc     = 0;
  int lock_at = 0;
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 3'h0;
    addr = '0;
  end
  always @(posedge clock) cyc <= cyc + 1;
  // One command on the next edge, then deselect
  task automatic issue(input logic [3:0] pins, input logic [2:0] b, input logic [12:0] a);
    @(posedge clock);
    #1;
    {cs_n, ras_n, cas_n, we_n} = pins;
    ba = b;
    addr = a;
    @(posedge clock);
    #1;
    // Deselected lines must not keep showing the last value
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = ~b;
    addr = ~a;
  endtask
  task automatic mrs(input logic [2:0] b, input logic [12:0] a);
    logic [12:0] v;
    v = a;
    if (b == BA_CFG0) v[TM_BIT] = 1'b0;
    if (b == BA_CFG0 && v[DLLRST_BIT]) lock_at = cyc + DLL_LOCK;
    issue(4'h0, b, v);
  endtask
  task automatic rd(input logic [2:0] ca, input logic bc);
    while (cyc < lock_at) @(posedge clock);
    issue(4'h5, 3'h0, {bc, 9'h000, ca});
  endtask
  task automatic wr(input logic [2:0] ca, input logic bc);
    issue(4'h4, 3'h0, {bc, 9'h000, ca});
  endtask
  // Back-to-back reads until the queue refuses, plus one that is dropped
  task automatic fill(output int acc);
    acc = 0;
    while (cyc < lock_at) @(posedge clock);
    @(posedge clock);
    #1;
    {cs_n, ras_n, cas_n, we_n} = 4'h5;
    ba = 3'h0;
    addr = 13'h1000;
    while (rd_cmd_ready === 1'b1 && acc < 60)
    begin
      @(posedge clock);
      #1;
      acc++;
    end
    @(posedge clock);
    #1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    addr = 13'h0fff;
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking testbench for the mode register decode block
`timescale 1ns/1ns
module testbench;
  import mrd_pkg::*;
  logic clock = 0, resetn = 0, sr_enter = 0, sr_exit = 0, odt = 0;
  logic [1:0] rtt_wr_code = 2'h0;
  logic cs_n, ras_n, cas_n, we_n, dll_enabled, dll_reset_pulse, pd_fast_exit;
  logic rd_cmd_ready, rd_beat_valid, rd_dq_oe, wr_start, wr_beat_valid, v_q;
  logic [2:0] ba, write_recovery, rd_beat_col, wr_beat_col;
  logic [12:0] addr, cfg0, cfg1;
  logic [4:0] cas_latency;
  logic [5:0] read_latency;
  logic [1:0] drive_code;
  mrd_term_t term_sel;
  int n_mismatch = 0, check_count = 0, n_burst = 0, acc;
  logic [1:0] rbl [6] = '{BL_FIX8, BL_FIX8, BL_FIX4, BL_OTF, BL_OTF, 2'h3};
  logic [2:0] rca [6] = '{3'h5, 3'h5, 3'h6, 3'h3, 3'h7, 3'h2};
  logic rbt [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic rbc [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic rch [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [1:0] wbl [3] = '{BL_FIX8, BL_FIX4, BL_OTF};
  logic [2:0] wca [3] = '{3'h3, 3'h5, 3'h4};
  logic wbc [3] = '{1'b1, 1'b1, 1'b0};
  int wn [3] = '{7, 5, 7};
  int wln [3] = '{8, 4, 4};
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    v_q <= rd_beat_valid;
    if (rd_beat_valid === 1'b1 && v_q === 1'b0) n_burst <= n_burst + 1;
  end
  mrd_ctrl_model i_ctrl (.clock(clock), .rd_cmd_ready(rd_cmd_ready), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
  mrd_mode_decode i_dut (.clock(clock), .resetn(resetn), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .sr_enter(sr_enter),
    .sr_exit(sr_exit), .odt(odt), .rtt_wr_code(rtt_wr_code),
    .burst_latency_config(cfg0), .dll_drive_term_config(cfg1),
    .cas_latency(cas_latency), .read_latency(read_latency),
    .write_recovery(write_recovery), .pd_fast_exit(pd_fast_exit),
    .drive_code(drive_code), .dll_enabled(dll_enabled),
    .dll_reset_pulse(dll_reset_pulse), .term_sel(term_sel),
    .rd_cmd_ready(rd_cmd_ready), .rd_beat_valid(rd_beat_valid),
    .rd_beat_col(rd_beat_col), .rd_dq_oe(rd_dq_oe), .wr_start(wr_start),
    .wr_beat_valid(wr_beat_valid), .wr_beat_col(wr_beat_col));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check_rd(input logic [2:0] ca, input logic il, input logic chop, input int rl);
    logic [2:0] k;
    logic [2:0] e;
    logic on;
    step(rl - 1);
    for (int i = 0; i < 8; i++)
    begin
      k = 3'(i);
      e = il ? ca ^ k : {ca[2] ^ k[2], ca[1:0] + k[1:0]};
      on = !(chop && i >= 4);
      chk("rd_valid", 16'(rd_beat_valid), 16'(on));
      chk("rd_oe", 16'(rd_dq_oe), 16'(on));
      if (on) chk("rd_col", 16'(rd_beat_col), 16'(e));
      step(1);
    end
    chk("rd_end", 16'(rd_beat_valid), 16'h0);
  endtask
  task automatic check_wr(input int n, input int len, input logic half);
    step(n - 2);
    chk("wr_early", 16'(wr_start), 16'h0);
    step(1);
    chk("wr_start", 16'(wr_start), 16'h1);
    for (int i = 0; i < len; i++)
    begin
      chk("wr_valid", 16'(wr_beat_valid), 16'h1);
      chk("wr_col", 16'(wr_beat_col), 16'(len == 8 ? i : {half, 2'(i)}));
      if (i == 2) chk("term_wr", 16'(term_sel), 16'(TERM_WR));
      step(1);
    end
    chk("wr_end", 16'(wr_beat_valid), 16'h0);
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    #3000000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    logic [12:0] v;
    int b0;
    repeat (6) @(posedge clock);
    #1 resetn = 1;
    step(2);
    chk("cfg0_rst", 16'(cfg0), 16'(CFG0_RST));
    chk("cfg1_rst", 16'(cfg1), 16'(CFG1_RST));
    chk("cl_rst", 16'(cas_latency), 16'h4);
    // Write recovery code 5 chosen above the minimum
    i_ctrl.mrs(BA_CFG0, 13'h1b10);
    chk("cfg0", 16'(cfg0), 16'h1b10);
    chk("cl", 16'(cas_latency), 16'h5);
    chk("wrec", 16'(write_recovery), 16'h5);
    chk("ppd", 16'(pd_fast_exit), 16'h1);
    step(1);
    chk("dllrst_clr", 16'(cfg0), 16'h1a10);
    chk("dllrst_pulse", 16'(dll_reset_pulse), 16'h1);
    // Nominal termination stays off, no write leveling
    i_ctrl.mrs(BA_CFG1, 13'h0028);
    chk("cfg1", 16'(cfg1), 16'h0028);
    chk("drive", 16'(drive_code), 16'h2);
    chk("rl", 16'(read_latency), 16'h9);
    for (int i = 0; i < 6; i++)
    begin
      v = 13'h1a10;
      v[BT_BIT] = rbt[i];
      v[1:0] = rbl[i];
      i_ctrl.mrs(BA_CFG0, v);
      i_ctrl.rd(rca[i], rbc[i]);
      check_rd(rca[i], rbt[i], rch[i], 9);
    end
    i_ctrl.mrs(BA_CFG0, 13'h1a14);
    chk("cl_a2", 16'(cas_latency), 16'hd);
    chk("rl_a2", 16'(read_latency), 16'h19);
    odt = 1'b1;
    rtt_wr_code = 2'h1;
    for (int i = 0; i < 3; i++)
    begin
      i_ctrl.mrs(BA_CFG0, {11'h0d0, wbl[i]});
      i_ctrl.wr(wca[i], wbc[i]);
      check_wr(wn[i], wln[i], wca[i][2]);
    end
    step(2);
    chk("term_off", 16'(term_sel), 16'(TERM_OFF));
    odt = 1'b0;
    sr_enter = 1'b1;
    step(1);
    sr_enter = 1'b0;
    step(2);
    chk("dll_sr", 16'(dll_enabled), 16'h0);
    sr_exit = 1'b1;
    step(1);
    sr_exit = 1'b0;
    step(2);
    chk("dll_exit", 16'(dll_enabled), 16'h1);
    // Nominal termination at one of the values allowed during writes
    i_ctrl.mrs(BA_CFG1, 13'h002c);
    odt = 1'b1;
    step(2);
    chk("term_nom", 16'(term_sel), 16'(TERM_NOM));
    odt = 1'b0;
    // DLL off with nominal termination cleared
    i_ctrl.mrs(BA_CFG1, 13'h0029);
    chk("dll_off", 16'(dll_enabled), 16'h0);
    b0 = n_burst;
    i_ctrl.fill(acc);
    chk("fill", 16'(acc >= FIFO_DEPTH), 16'h1);
    for (int i = 0, idle = 0; i < 2000 && idle < 40; i++)
    begin
      step(1);
      idle = (rd_beat_valid === 1'b1) ? 0 : idle + 1;
    end
    chk("bursts", 16'(n_burst - b0), 16'(acc));
    chk("ready", 16'(rd_cmd_ready), 16'h1);
    wrap_up();
  end
endmodule
